/* File: kpi_consts.vh */
// Constants for the keypad event and interrupt configuration block
`ifndef KPI_CONSTS_VH
`define KPI_CONSTS_VH

// Register offsets
`define KPI_ADDR_CORE_CONFIG   8'h01
`define KPI_ADDR_IRQ_FLAGS     8'h02
`define KPI_ADDR_EVENT_POP     8'h03
`define KPI_ADDR_EVENT_LEVEL   8'h04

// Reset values
`define KPI_CORE_CONFIG_RST    8'h00
`define KPI_IRQ_FLAGS_RST      5'h00

// Configuration field positions
`define KPI_CFG_AUTO_STEP      7
`define KPI_CFG_LOCKED_INPUT   6
`define KPI_CFG_SPILL_WRAP     5
`define KPI_CFG_RETRIGGER      4
`define KPI_CFG_SPILL_ALERT    3
`define KPI_CFG_LOCK_ALERT     2

// Flag field positions
`define KPI_FLG_SALUTE         4
`define KPI_FLG_SPILL          3
`define KPI_FLG_LOCK           2
`define KPI_FLG_INPUT          1
`define KPI_FLG_KEY            0
`define KPI_FLG_W              5

// Event queue shape
`define KPI_EVT_W              8
`define KPI_EVT_DEPTH          10

// Key numbers watched by the salute detector
`define KPI_KEY_A              7'h01
`define KPI_KEY_B              7'h0B
`define KPI_KEY_C              7'h15

// Re-trigger gap: 50 us at a 50 ns clock period
`define KPI_GAP_NS             50000
`define KPI_CLK_NS             50
`define KPI_GAP_CYC            (`KPI_GAP_NS / `KPI_CLK_NS)
`define KPI_GAP_W              10

`endif

/* File: kpi_event_fifo.v */
// Event queue: flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ns
module kpi_event_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 10,
   parameter AW    = 4
)(
   input  wire             clk_i,
   input  wire             rst_n_i,
   input  wire             in_valid_i,
   input  wire [WIDTH-1:0] in_data_i,
   output wire             in_ready_o,
   output wire             out_valid_o,
   output wire [WIDTH-1:0] out_data_o,
   input  wire             out_ready_i,
   output wire [AW-1:0]    level_o
);
   reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg  [AW-1:0]    wr_q;
   reg  [AW-1:0]    rd_q;
   reg  [AW-1:0]    cnt_q;
   wire             full  = (cnt_q == DEPTH[AW-1:0]);
   wire             empty = (cnt_q == {AW{1'b0}});
   wire             pop   = out_ready_i & ~empty;
   // A push into a full queue is accepted only when a pop frees a slot in the same cycle
   wire             push  = in_valid_i & (~full | pop);
   integer          i;

   assign in_ready_o  = ~full;
   assign out_valid_o = ~empty;
   assign out_data_o  = mem_q[rd_q];
   assign level_o     = cnt_q;

   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {AW{1'b0}};
         for (i = 0; i < DEPTH; i = i + 1)
            mem_q[i] <= {WIDTH{1'b0}};
      end
      else
      begin
         if (push)
         begin
            mem_q[wr_q] <= in_data_i;
            wr_q        <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
         end
         if (pop)
            rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
         if (push & ~pop)
            cnt_q <= cnt_q + 1'b1;
         else if (pop & ~push)
            cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule

/* File: kpi_salute_detect.v */
// Three-key salute detector, including the false combinations of the shipped part
`timescale 1ns/1ns
`include "kpi_consts.vh"
module kpi_salute_detect (
   input  wire                  clk_i,
   input  wire                  rst_n_i,
   input  wire                  key_evt_i,
   input  wire [`KPI_EVT_W-1:0] key_code_i,
   output reg                   hit_o
);
   reg        held_a_q;
   reg        held_b_q;
   reg        held_c_q;
   reg        combo_q;
   wire       press = key_code_i[7];
   wire [6:0] num   = key_code_i[6:0];
   // Key A with either B or C already counts; this covers the true combo and the faulty ones
   wire       combo = held_a_q & (held_b_q | held_c_q);

   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         held_a_q <= 1'b0;
         held_b_q <= 1'b0;
         held_c_q <= 1'b0;
         combo_q  <= 1'b0;
         hit_o    <= 1'b0;
      end
      else
      begin
         if (key_evt_i && num == `KPI_KEY_A)
            held_a_q <= press;
         if (key_evt_i && num == `KPI_KEY_B)
            held_b_q <= press;
         if (key_evt_i && num == `KPI_KEY_C)
            held_c_q <= press;
         combo_q <= combo;
         hit_o   <= combo & ~combo_q;
      end
   end
endmodule

/* File: kpi_irq_core.v */
// Keypad event queue, interrupt flags, configuration byte and interrupt output
// Functional notes
// - Ten-byte event queue of key and input events; detects an event arriving while full.
// - Flag bit 4 sets on three-key salute; holds until host writes one.
// - Salute flag also sets on keys 1+11, 1+21 and 21+1+11.
// - Flag bit 3 reports queue spill; cleared only by host writing one.
// - Flag bit 2 sets when keypad lock sequence starts; write one clears.
// - Flag bit 1 reports input events; write one clears only while no event waits in the queue.
// - Flag bit 0 reports key events; write one clears only while no event waits in the queue.
// - Spill flag raised only when spill alert enable and wrap mode both set.
// - Wrap mode off drops new events at full; on, newest displaces oldest.
// - Spill flag raised as the queue overflows, an event already lost.
// - Config bit 7 enables register address auto increment for reads and writes.
// - Config bit 6 set stops tracking input events while keypad locked.
// - Config bit 4 clear: interrupt stays low on clear attempt with pending events.
// - Config bit 4 set: such a clear releases interrupt 50 us, then reasserts.
// - Config bit 2 enables the keypad lock interrupt.
`timescale 1ns/1ns
`include "kpi_consts.vh"
module kpi_irq_core (
   input  wire                  MCLK_I,
   input  wire                  RESET_N_I,
   input  wire                  KEY_EVT_I,
   input  wire [`KPI_EVT_W-1:0] KEY_CODE_I,
   input  wire                  GPI_EVT_I,
   input  wire [`KPI_EVT_W-1:0] GPI_CODE_I,
   input  wire                  KEYPAD_LOCKED_I,
   input  wire                  LOCK_START_I,
   input  wire                  REG_ADDR_LOAD_I,
   input  wire [7:0]            REG_ADDR_I,
   input  wire                  REG_WR_I,
   input  wire [7:0]            REG_WDATA_I,
   input  wire                  REG_RD_I,
   output reg  [7:0]            REG_RDATA_O,
   output reg                   REG_RVALID_O,
   output reg                   INT_N_O,
   output reg                   EVT_DROP_O
);
   reg  [7:0]             core_config_q;
   reg  [`KPI_FLG_W-1:0]  irq_flags_q;
   reg  [`KPI_FLG_W-1:0]  irq_flags_d;
   reg  [7:0]             ptr_q;
   reg  [`KPI_GAP_W-1:0]  gap_q;
   reg  [7:0]             rdata_d;

   // Gap length kept as an integer, loaded through an explicit slice of the counter width
   localparam integer     GAP_CYC = `KPI_GAP_CYC;

   wire                   salute_hit;
   wire                   fifo_in_ready;
   wire                   fifo_out_valid;
   wire [`KPI_EVT_W-1:0]  fifo_out_data;
   wire [3:0]             fifo_level;

   wire auto_step    = core_config_q[`KPI_CFG_AUTO_STEP];
   wire lock_quiet   = core_config_q[`KPI_CFG_LOCKED_INPUT];
   wire spill_wrap   = core_config_q[`KPI_CFG_SPILL_WRAP];
   wire retrigger    = core_config_q[`KPI_CFG_RETRIGGER];
   wire spill_alert  = core_config_q[`KPI_CFG_SPILL_ALERT];
   wire lock_alert   = core_config_q[`KPI_CFG_LOCK_ALERT];

   // Register access: a fresh address overrides the running pointer
   wire       access   = REG_WR_I | REG_RD_I;
   wire [7:0] acc_addr = REG_ADDR_LOAD_I ? REG_ADDR_I : ptr_q;
   wire       wr_cfg   = REG_WR_I & (acc_addr == `KPI_ADDR_CORE_CONFIG);
   wire       wr_flags = REG_WR_I & (acc_addr == `KPI_ADDR_IRQ_FLAGS);
   wire       rd_pop   = REG_RD_I & (acc_addr == `KPI_ADDR_EVENT_POP);

   // Input events are suppressed while locked only when the host asks for it
   wire       gpi_track = GPI_EVT_I & ~(KEYPAD_LOCKED_I & lock_quiet);
   // Key events win when both arrive in one cycle; the input event is then not queued
   wire       gpi_push  = gpi_track & ~KEY_EVT_I;
   wire       evt_valid = KEY_EVT_I | gpi_push;
   wire [`KPI_EVT_W-1:0] evt_data = KEY_EVT_I ? KEY_CODE_I : GPI_CODE_I;

   wire       q_full    = ~fifo_in_ready;
   wire       spill     = evt_valid & q_full;
   // Wrap mode frees the oldest slot so the new event goes in; otherwise it is dropped
   wire       wrap_pop  = spill & spill_wrap;
   wire       host_pop  = rd_pop & fifo_out_valid;
   wire       fifo_pop  = host_pop | wrap_pop;

   // Overflow alert needs both enable and wrap mode, a quirk kept on purpose
   wire       spill_set = spill & spill_alert & spill_wrap;

   wire [`KPI_FLG_W-1:0] flag_set;
   wire [`KPI_FLG_W-1:0] flag_clr;
   wire [`KPI_FLG_W-1:0] flag_mask;
   wire                  pending;
   wire                  blocked_clr;
   wire                  int_active;

   assign flag_set[`KPI_FLG_SALUTE] = salute_hit;
   assign flag_set[`KPI_FLG_SPILL]  = spill_set;
   assign flag_set[`KPI_FLG_LOCK]   = LOCK_START_I;
   assign flag_set[`KPI_FLG_INPUT]  = gpi_track;
   assign flag_set[`KPI_FLG_KEY]    = KEY_EVT_I;

   // Only ones in the written byte clear; upper bits of the byte are ignored
   assign flag_clr = wr_flags ? REG_WDATA_I[`KPI_FLG_W-1:0] : {`KPI_FLG_W{1'b0}};

   // Key and input flags cannot be cleared while events still wait in the queue
   assign pending     = fifo_out_valid & ~host_pop;
   assign blocked_clr = pending & (|(flag_clr[1:0] & irq_flags_q[1:0]));

   assign flag_mask = {1'b1, 1'b1, lock_alert, 1'b1, 1'b1};
   assign int_active = |(irq_flags_q & flag_mask);

   always @*
   begin
      irq_flags_d = flag_set | (irq_flags_q & ~flag_clr);
      if (pending)
         irq_flags_d[1:0] = irq_flags_d[1:0] | (irq_flags_q[1:0] & flag_clr[1:0]);
   end

   always @*
   begin
      rdata_d = 8'h00;
      case (acc_addr)
         `KPI_ADDR_CORE_CONFIG:
            rdata_d = core_config_q;
         `KPI_ADDR_IRQ_FLAGS:
            rdata_d = {3'b000, irq_flags_q};
         `KPI_ADDR_EVENT_POP:
            rdata_d = fifo_out_valid ? fifo_out_data : 8'h00;
         `KPI_ADDR_EVENT_LEVEL:
            rdata_d = {4'h0, fifo_level};
         default:
            rdata_d = 8'h00;
      endcase
   end

   kpi_event_fifo #(
      .WIDTH (`KPI_EVT_W),
      .DEPTH (`KPI_EVT_DEPTH),
      .AW    (4)
   ) u_fifo (
      .clk_i       (MCLK_I),
      .rst_n_i     (RESET_N_I),
      .in_valid_i  (evt_valid),
      .in_data_i   (evt_data),
      .in_ready_o  (fifo_in_ready),
      .out_valid_o (fifo_out_valid),
      .out_data_o  (fifo_out_data),
      .out_ready_i (fifo_pop),
      .level_o     (fifo_level)
   );

   kpi_salute_detect u_salute (
      .clk_i      (MCLK_I),
      .rst_n_i    (RESET_N_I),
      .key_evt_i  (KEY_EVT_I),
      .key_code_i (KEY_CODE_I),
      .hit_o      (salute_hit)
   );

   always @(posedge MCLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         core_config_q <= `KPI_CORE_CONFIG_RST;
         irq_flags_q   <= `KPI_IRQ_FLAGS_RST;
         ptr_q         <= 8'h00;
         REG_RDATA_O   <= 8'h00;
         REG_RVALID_O  <= 1'b0;
         EVT_DROP_O    <= 1'b0;
      end
      else
      begin
         irq_flags_q  <= irq_flags_d;
         REG_RVALID_O <= REG_RD_I;
         EVT_DROP_O   <= spill & ~spill_wrap;
         if (wr_cfg)
            core_config_q <= REG_WDATA_I;
         if (REG_RD_I)
            REG_RDATA_O <= rdata_d;
         if (access)
            ptr_q <= auto_step ? acc_addr + 8'h01 : acc_addr;
         else if (REG_ADDR_LOAD_I)
            ptr_q <= REG_ADDR_I;
      end
   end

   // Re-trigger gap gives the host a clean edge when it clears too early
   always @(posedge MCLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         gap_q   <= {`KPI_GAP_W{1'b0}};
         INT_N_O <= 1'b1;
      end
      else
      begin
         if (blocked_clr & retrigger)
            gap_q <= GAP_CYC[`KPI_GAP_W-1:0];
         else if (gap_q != {`KPI_GAP_W{1'b0}})
            gap_q <= gap_q - 1'b1;
         if (blocked_clr & retrigger)
            INT_N_O <= 1'b1;
         else
            INT_N_O <= ~(|(irq_flags_d & flag_mask) & (gap_q <= 10'h001));
      end
   end
endmodule

/* File: kpi_irq_monitor.sv */
// Port-level assertions for the keypad interrupt core
`timescale 1ns/1ns
module kpi_irq_monitor (
   input wire       MCLK_I,
   input wire       RESET_N_I,
   input wire       KEY_EVT_I,
   input wire       GPI_EVT_I,
   input wire       REG_ADDR_LOAD_I,
   input wire [7:0] REG_ADDR_I,
   input wire       REG_WR_I,
   input wire       REG_RD_I,
   input wire [7:0] REG_RDATA_O,
   input wire       REG_RVALID_O,
   input wire       INT_N_O,
   input wire       EVT_DROP_O
);
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (!RESET_N_I);
   a_reset_quiet: assert property ($rose(RESET_N_I) |-> INT_N_O && !REG_RVALID_O && !EVT_DROP_O)
      else $error("Outputs busy after reset");
   a_read_answers: assert property (REG_RD_I |=> REG_RVALID_O)
      else $error("Read not answered in one cycle");
   a_answer_cause: assert property (REG_RVALID_O |-> $past(REG_RD_I))
      else $error("Read valid without a read");
   a_rdata_holds: assert property (!REG_RVALID_O |-> $stable(REG_RDATA_O))
      else $error("Read data moved outside a read");
   a_flag_top_zero: assert property (REG_RVALID_O && $past(REG_ADDR_LOAD_I) && $past(REG_ADDR_I) == 8'h02
      |-> REG_RDATA_O[7:5] == 3'b000) else $error("Unused flag bits not zero");
   a_drop_cause: assert property (EVT_DROP_O |-> $past(KEY_EVT_I) || $past(GPI_EVT_I))
      else $error("Drop without an event");
   a_int_rise_write: assert property ($rose(INT_N_O) |-> $past(REG_WR_I) || $past(REG_WR_I, 2))
      else $error("Interrupt released without a write");
   a_key_keeps_int: assert property (KEY_EVT_I && !INT_N_O && !REG_WR_I && !$past(REG_WR_I) |=> !INT_N_O)
      else $error("Interrupt released on a key event");
endmodule

/* File: kpi_host_model.sv */
// Host-side register master for the core's register port
`timescale 1ns/1ns
module kpi_host_model (
   input  wire       clk_i,
   output reg        addr_load_o,
   output reg  [7:0] addr_o,
   output reg        wr_o,
   output reg  [7:0] wdata_o,
   output reg        rd_o,
   input  wire [7:0] rdata_i,
   input  wire       rvalid_i
);
   initial {addr_load_o, addr_o, wr_o, wdata_o, rd_o} = 19'h0;
   // Idle buses carry the inverse so a stale value is never mistaken for a fresh one
   task acc(input bit ld, input bit w, input [7:0] a, input [7:0] d, output [7:0] q, output logic v);
      begin
         @(negedge clk_i);
         {addr_load_o, wr_o, rd_o, addr_o, wdata_o} = {ld, w, !w, a, d};
         @(negedge clk_i);
         {addr_load_o, wr_o, rd_o, addr_o, wdata_o} = {3'b000, ~a, ~d};
         q = rdata_i;
         v = rvalid_i;
      end
   endtask
endmodule

/* File: tb_top.sv */
// Self-checking bench for the keypad interrupt core
`timescale 1ns/1ns
`include "kpi_consts.vh"
module tb_top;
   logic       MCLK_I = 0, RESET_N_I = 0, KEY_EVT_I = 0, GPI_EVT_I = 0, KEYPAD_LOCKED_I = 0, LOCK_START_I = 0;
   logic [7:0] KEY_CODE_I = 8'h00, GPI_CODE_I = 8'h00, q;
   wire  [7:0] adr, wd, rdat;
   wire        ld, wr, rd, rv, int_n, drop;
   logic       v;
   int         fail_count = 0, n_tests = 0, i, j, n, c;
   logic [7:0] combo [4][3] = '{'{8'h01, 8'h0B, 8'h00}, '{8'h01, 8'h15, 8'h00}, '{8'h15, 8'h01, 8'h0B},
                                '{8'h01, 8'h0B, 8'h15}};
   always #25 MCLK_I = ~MCLK_I;
   kpi_irq_core dut (.MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .KEY_EVT_I(KEY_EVT_I), .KEY_CODE_I(KEY_CODE_I),
      .GPI_EVT_I(GPI_EVT_I), .GPI_CODE_I(GPI_CODE_I), .KEYPAD_LOCKED_I(KEYPAD_LOCKED_I),
      .LOCK_START_I(LOCK_START_I), .REG_ADDR_LOAD_I(ld), .REG_ADDR_I(adr), .REG_WR_I(wr), .REG_WDATA_I(wd),
      .REG_RD_I(rd), .REG_RDATA_O(rdat), .REG_RVALID_O(rv), .INT_N_O(int_n), .EVT_DROP_O(drop));
   kpi_host_model host (.clk_i(MCLK_I), .addr_load_o(ld), .addr_o(adr), .wr_o(wr), .wdata_o(wd), .rd_o(rd),
      .rdata_i(rdat), .rvalid_i(rv));
   task check(input logic [15:0] seen, input logic [15:0] exp);
      begin
         n_tests++;
         if (seen !== exp)
         begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task wr_reg(input [7:0] a, input [7:0] d);
      host.acc(1, 1, a, d, q, v);
   endtask
   task rd_reg(input [7:0] a);
      begin
         host.acc(1, 0, a, 8'h00, q, v);
         check(v, 1);
      end
   endtask
   task key(input [7:0] k);
      begin
         @(negedge MCLK_I);
         {KEY_EVT_I, KEY_CODE_I} = {1'b1, k};
         @(negedge MCLK_I);
         {KEY_EVT_I, KEY_CODE_I} = {1'b0, ~k};
      end
   endtask
   task drain;
      begin
         rd_reg(`KPI_ADDR_EVENT_LEVEL);
         n = q;
         for (j = 0; j < n; j++)
            rd_reg(`KPI_ADDR_EVENT_POP);
         wr_reg(`KPI_ADDR_IRQ_FLAGS, 8'h1F);
         rd_reg(`KPI_ADDR_IRQ_FLAGS);
         check(q, 8'h00);
      end
   endtask
   task t_basic;
      begin
         rd_reg(`KPI_ADDR_CORE_CONFIG);
         check(q, `KPI_CORE_CONFIG_RST);
         rd_reg(`KPI_ADDR_IRQ_FLAGS);
         check({q, int_n}, {8'h00, 1'b1});
         key(8'h82);
         @(negedge MCLK_I);
         check(int_n, 0);
         wr_reg(`KPI_ADDR_IRQ_FLAGS, 8'h00);
         rd_reg(`KPI_ADDR_IRQ_FLAGS);
         check(q, 8'h01);
         wr_reg(`KPI_ADDR_IRQ_FLAGS, 8'hFF);
         rd_reg(`KPI_ADDR_IRQ_FLAGS);
         check({q, int_n}, {8'h01, 1'b0});
         rd_reg(`KPI_ADDR_EVENT_POP);
         check(q, 8'h82);
         wr_reg(`KPI_ADDR_IRQ_FLAGS, 8'h01);
         @(negedge MCLK_I);
         check(int_n, 1);
      end
   endtask
   task t_auto;
      begin
         wr_reg(`KPI_ADDR_CORE_CONFIG, 8'h80);
         rd_reg(`KPI_ADDR_CORE_CONFIG);
         host.acc(0, 0, 8'h00, 8'h00, q, v);
         check(q, 8'h00);
         wr_reg(`KPI_ADDR_CORE_CONFIG, 8'h00);
      end
   endtask
   task gpi(input logic lk, input [7:0] cfg, input [7:0] exp);
      begin
         wr_reg(`KPI_ADDR_CORE_CONFIG, cfg);
         KEYPAD_LOCKED_I = lk;
         @(negedge MCLK_I);
         {GPI_EVT_I, GPI_CODE_I} = {1'b1, 8'hE3};
         @(negedge MCLK_I);
         {GPI_EVT_I, GPI_CODE_I, KEYPAD_LOCKED_I} = {1'b0, 8'h1C, 1'b0};
         rd_reg(`KPI_ADDR_IRQ_FLAGS);
         check(q, exp);
         drain;
      end
   endtask
   task t_lock;
      begin
         @(negedge MCLK_I);
         LOCK_START_I = 1;
         @(negedge MCLK_I);
         LOCK_START_I = 0;
         rd_reg(`KPI_ADDR_IRQ_FLAGS);
         check({q, int_n}, {8'h04, 1'b1});
         wr_reg(`KPI_ADDR_CORE_CONFIG, 8'h04);
         @(negedge MCLK_I);
         check(int_n, 0);
         drain;
         check(int_n, 1);
         wr_reg(`KPI_ADDR_CORE_CONFIG, 8'h00);
      end
   endtask
   task t_salute;
      for (c = 0; c < 4; c++)
      begin
         for (i = 0; i < 3; i++)
            if (combo[c][i] != 8'h00) key(combo[c][i] | 8'h80);
         // Detector registers its hit, so the flag lands two edges after the last press
         @(negedge MCLK_I);
         rd_reg(`KPI_ADDR_IRQ_FLAGS);
         check(q[`KPI_FLG_SALUTE], 1);
         for (i = 0; i < 3; i++)
            if (combo[c][i] != 8'h00) key(combo[c][i]);
         drain;
      end
   endtask
   // Eleven events: the last one meets a full queue
   task fill(input [7:0] cfg);
      begin
         wr_reg(`KPI_ADDR_CORE_CONFIG, cfg);
         for (i = 0; i < 11; i++)
         begin
            key(8'h82 + i[7:0]);
            check(drop, (i == 10) && !cfg[5]);
         end
         rd_reg(`KPI_ADDR_EVENT_LEVEL);
         check(q, `KPI_EVT_DEPTH);
         rd_reg(`KPI_ADDR_IRQ_FLAGS);
         check(q[`KPI_FLG_SPILL], cfg[3] & cfg[5]);
         rd_reg(`KPI_ADDR_EVENT_POP);
         check(q, cfg[5] ? 8'h83 : 8'h82);
         drain;
      end
   endtask
   task t_gap;
      begin
         wr_reg(`KPI_ADDR_CORE_CONFIG, 8'h10);
         key(8'h82);
         wr_reg(`KPI_ADDR_IRQ_FLAGS, 8'h01);
         for (n = 0; n < 1100 && int_n === 1'b1; n++)
            @(negedge MCLK_I);
         check(n, `KPI_GAP_CYC);
         drain;
      end
   endtask
   task final_report;
      begin
         if (fail_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   initial
   begin
      repeat (6) @(negedge MCLK_I);
      RESET_N_I = 1;
      t_basic;
      t_auto;
      gpi(1, 8'h40, 8'h00);
      gpi(1, 8'h00, 8'h02);
      t_lock;
      t_salute;
      fill(8'h08);
      fill(8'h28);
      fill(8'h20);
      t_gap;
      final_report;
   end
   initial
   begin
      #2000000;
      fail_count++;
      final_report;
   end
endmodule
bind kpi_irq_core kpi_irq_monitor mon (.MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .KEY_EVT_I(KEY_EVT_I),
   .GPI_EVT_I(GPI_EVT_I), .REG_ADDR_LOAD_I(REG_ADDR_LOAD_I), .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I),
   .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O), .INT_N_O(INT_N_O),
   .EVT_DROP_O(EVT_DROP_O));
